// File: hw/orta_bank.v
`timescale 1ns/1ns
`default_nettype none
`include "orta_defs.vh"
module orta_bank (
	input wire clk,
	input wire rst,
	input wire reg_wr,
	input wire reg_rd,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	output reg [7:0] reg_rdata,
	input wire status_rd,
	input wire result_valid,
	input wire [2:0] result_ch,
	input wire [11:0] result_data,
	output reg [4:0] channel_alarm_flag,
	output reg temp_over_flag,
	output reg temp_under_flag,
	output reg global_alarm_flag
);
	// Byte storage: index = addr - 0x80; 0..19 analog, 20..23 temperature
	reg [7:0] bytes_q [0:`ORTA_NUM_BYTES-1];
	reg [7:0] rdata_d;
	reg [7:0] offset_d;
	reg [4:0] idx;
	reg hit;
	reg [4:0] ch_d;
	reg tover_d;
	reg tunder_d;
	reg alarm_any;
	integer j;

	// Assembled bounds, one pair per channel
	wire [11:0] up_0;
	wire [11:0] lo_0;
	wire [11:0] up_1;
	wire [11:0] lo_1;
	wire [11:0] up_2;
	wire [11:0] lo_2;
	wire [11:0] up_3;
	wire [11:0] lo_3;
	wire [11:0] up_4;
	wire [11:0] lo_4;
	wire [11:0] t_up;
	wire [11:0] t_lo;

	// Window results, taken only with the strobe
	wire [4:0] win_out;
	wire t_over;
	wire t_under;

	function [11:0] bound;
		input [7:0] lo;
		input [7:0] hi;
		begin
			bound = {hi[3:0], lo};
		end
	endfunction

	function out_u;
		input [11:0] v;
		input [11:0] up;
		input [11:0] lo;
		begin
			out_u = (v > up) || (v < lo);
		end
	endfunction

	function over_s;
		input [11:0] v;
		input [11:0] lim;
		begin
			over_s = $signed(v) > $signed(lim);
		end
	endfunction

	function under_s;
		input [11:0] v;
		input [11:0] lim;
		begin
			under_s = $signed(v) < $signed(lim);
		end
	endfunction

	// Reset value of each byte
	function [7:0] rst_val;
		input [4:0] k;
		begin
			case (k)
				5'h14: rst_val = `ORTA_TUP_LO_RST;
				5'h15: rst_val = `ORTA_TUP_HI_RST;
				5'h16: rst_val = `ORTA_TLO_LO_RST;
				5'h17: rst_val = `ORTA_TLO_HI_RST;
				default: begin
					case (k[1:0])
						2'h0: rst_val = `ORTA_UP_LO_RST;
						2'h1: rst_val = `ORTA_UP_HI_RST;
						2'h2: rst_val = `ORTA_LO_LO_RST;
						default: rst_val = `ORTA_LO_HI_RST;
					endcase
				end
			endcase
		end
	endfunction

	always @* begin
		offset_d = reg_addr - `ORTA_ANALOG_BASE;
		idx = offset_d[4:0];
		hit = (reg_addr >= `ORTA_ANALOG_BASE) && (reg_addr <= `ORTA_TEMP_LO_HI);
	end

	always @(posedge clk) begin
		if (rst) begin
			for (j = 0; j < `ORTA_NUM_BYTES; j = j + 1) begin
				bytes_q[j] <= rst_val(j[4:0]);
			end
		end else if (reg_wr && hit) begin
			bytes_q[idx] <= reg_wdata;
		end
	end

	always @* begin
		rdata_d = 8'h00;
		if (hit) begin
			rdata_d = bytes_q[idx];
		end
	end

	always @(posedge clk) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			reg_rdata <= rdata_d;
		end
	end

	assign up_0 = bound(bytes_q[0], bytes_q[1]);
	assign lo_0 = bound(bytes_q[2], bytes_q[3]);

	assign up_1 = bound(bytes_q[4], bytes_q[5]);
	assign lo_1 = bound(bytes_q[6], bytes_q[7]);

	assign up_2 = bound(bytes_q[8], bytes_q[9]);
	assign lo_2 = bound(bytes_q[10], bytes_q[11]);

	assign up_3 = bound(bytes_q[12], bytes_q[13]);
	assign lo_3 = bound(bytes_q[14], bytes_q[15]);

	assign up_4 = bound(bytes_q[16], bytes_q[17]);
	assign lo_4 = bound(bytes_q[18], bytes_q[19]);

	assign t_up = bound(bytes_q[20], bytes_q[21]);
	assign t_lo = bound(bytes_q[22], bytes_q[23]);

	assign win_out[0] = out_u(result_data, up_0, lo_0);
	assign win_out[1] = out_u(result_data, up_1, lo_1);
	assign win_out[2] = out_u(result_data, up_2, lo_2);
	assign win_out[3] = out_u(result_data, up_3, lo_3);
	assign win_out[4] = out_u(result_data, up_4, lo_4);

	assign t_over = over_s(result_data, t_up);
	assign t_under = under_s(result_data, t_lo);

	always @* begin
		ch_d = channel_alarm_flag;
		tover_d = temp_over_flag;
		tunder_d = temp_under_flag;
		if (result_valid && (result_ch == 3'h0)) begin
			ch_d[0] = win_out[0];
		end

		if (result_valid && (result_ch == 3'h1)) begin
			ch_d[1] = win_out[1];
		end

		if (result_valid && (result_ch == 3'h2)) begin
			ch_d[2] = win_out[2];
		end

		if (result_valid && (result_ch == 3'h3)) begin
			ch_d[3] = win_out[3];
		end

		if (result_valid && (result_ch == 3'h4)) begin
			ch_d[4] = win_out[4];
		end
		if (result_valid && (result_ch == `ORTA_CH_TEMP)) begin
			tover_d = t_over;
			tunder_d = t_under;
		end
		alarm_any = (|ch_d) || tover_d || tunder_d;
	end

	always @(posedge clk) begin
		if (rst) begin
			channel_alarm_flag <= 5'h00;
			temp_over_flag <= 1'b0;
			temp_under_flag <= 1'b0;
			global_alarm_flag <= 1'b0;
		end else begin
			channel_alarm_flag <= ch_d;
			temp_over_flag <= tover_d;
			temp_under_flag <= tunder_d;
			if (alarm_any) begin
				global_alarm_flag <= 1'b1;
			end else if (status_rd) begin
				global_alarm_flag <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

// File: hw/orta_defs.vh
`ifndef ORTA_DEFS_VH
`define ORTA_DEFS_VH
`define ORTA_ANALOG_BASE 8'h80
`define ORTA_ANALOG_LAST 8'h93
`define ORTA_TEMP_UP_LO 8'h94
`define ORTA_TEMP_UP_HI 8'h95
`define ORTA_TEMP_LO_LO 8'h96
`define ORTA_TEMP_LO_HI 8'h97
`define ORTA_UP_LO_RST 8'hFF
`define ORTA_UP_HI_RST 8'h0F
`define ORTA_LO_LO_RST 8'h00
`define ORTA_LO_HI_RST 8'h00
`define ORTA_TUP_LO_RST 8'hFF
`define ORTA_TUP_HI_RST 8'h07
`define ORTA_TLO_LO_RST 8'h00
`define ORTA_TLO_HI_RST 8'h08
`define ORTA_NUM_CH 5
`define ORTA_NUM_BYTES 24
`define ORTA_CH_TEMP 3'h5
`endif

// File: tb/orta_bank_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module orta_chk (
	input wire logic clk,
	input wire logic rst,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_rdata,
	input wire logic status_rd,
	input wire logic result_valid,
	input wire logic [2:0] result_ch,
	input wire logic [4:0] channel_alarm_flag,
	input wire logic temp_over_flag,
	input wire logic temp_under_flag,
	input wire logic global_alarm_flag
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	chk_unmap_read: assert property (reg_rd && reg_addr > 8'h97 |=> reg_rdata == 8'h00) else $error("rd");
	chk_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata)) else $error("rh");
	chk_glob_or: assert property (|channel_alarm_flag |-> global_alarm_flag) else $error("or");
	chk_glob_temp: assert property (temp_over_flag || temp_under_flag |-> global_alarm_flag) else $error("ot");
	chk_glob_keep: assert property (global_alarm_flag && !status_rd |=> global_alarm_flag) else $error("gk");
	chk_glob_clear: assert property (
		status_rd && !result_valid && {channel_alarm_flag, temp_over_flag, temp_under_flag} == 7'h00
		|=> !global_alarm_flag) else $error("gc");
	chk_flag_hold: assert property (!result_valid |=> $stable(channel_alarm_flag)) else $error("fh");
	chk_temp_hold: assert property (
		!result_valid |=> $stable({temp_over_flag, temp_under_flag})) else $error("th");
	chk_bad_ch: assert property (
		result_valid && result_ch > 3'h5 |=> $stable({channel_alarm_flag, temp_over_flag, temp_under_flag}))
		else $error("bc");
	chk_temp_only: assert property (result_valid && result_ch == 3'h5 |=> $stable(channel_alarm_flag)) else $error("tc");
endmodule
bind orta_bank orta_chk u_chk (.*);
`default_nettype wire

// File: tb/orta_bank_bench.sv
`timescale 1ns/1ns
`default_nettype none
`define CK(a,b) begin tests_run++; if ((a) !== (b)) begin bad_count++; $display("[ERR] %0t %h %h", $time, a, b); end end
module orta_bank_bench;
	logic clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, status_rd = 0, result_valid = 0;
	logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata;
	logic [2:0] result_ch = 0;
	logic [11:0] result_data = 0;
	logic [4:0] channel_alarm_flag;
	logic temp_over_flag, temp_under_flag, global_alarm_flag;
	logic [7:0] rv [8] = '{8'hFF, 8'h0F, 8'h00, 8'h00, 8'hFF, 8'h07, 8'h00, 8'h08};
	int bad_count = 0, tests_run = 0;
	orta_bank DUT (
		.clk(clk),
		.rst(rst),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata),
		.status_rd(status_rd),
		.result_valid(result_valid),
		.result_ch(result_ch),
		.result_data(result_data),
		.channel_alarm_flag(channel_alarm_flag),
		.temp_over_flag(temp_over_flag),
		.temp_under_flag(temp_under_flag),
		.global_alarm_flag(global_alarm_flag)
	);
	initial forever #2 clk = ~clk;
	task wr(input [7:0] a, input [7:0] d);
		@(posedge clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
		@(posedge clk) reg_wr <= 0;
	endtask
	task rd(input [7:0] a, input [7:0] e);
		@(posedge clk) {reg_rd, reg_addr} <= {1'b1, a};
		@(posedge clk) reg_rd <= 0;
		#1 `CK(reg_rdata, e)
	endtask
	// Flags packed as channel bits, over, under
	task rs(input [2:0] c, input [11:0] d, input [6:0] e);
		@(posedge clk) {result_valid, result_ch, result_data} <= {1'b1, c, d};
		@(posedge clk) result_valid <= 0;
		#1 `CK({channel_alarm_flag, temp_over_flag, temp_under_flag}, e)
	endtask
	task final_report;
		$display("checks %0d errors %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge clk);
		rst <= 0;
		for (int i = 0; i < 8; i++) rd(i < 4 ? 8'h80 + i : 8'h90 + i, rv[i]);
		rd(8'h98, 8'h00);
		wr(8'h81, 8'hF1);
		rd(8'h81, 8'hF1);
		rs(3'h0, 12'h1FF, 7'h00);
		rs(3'h0, 12'hFFF, 7'h04);
		rs(3'h0, 12'h100, 7'h00);
		`CK(global_alarm_flag, 1'b1)
		@(posedge clk) status_rd <= 1'b1;
		@(posedge clk) status_rd <= 1'b0;
		#1 `CK(global_alarm_flag, 1'b0)
		wr(8'h92, 8'h10);
		rs(3'h4, 12'h010, 7'h00);
		rs(3'h4, 12'h00F, 7'h40);
		wr(8'h85, 8'h00);
		wr(8'h87, 8'h01);
		rs(3'h1, 12'h0FF, 7'h48);
		rs(3'h5, 12'h800, 7'h48);
		rs(3'h5, 12'h7FF, 7'h48);
		wr(8'h97, 8'h0F);
		wr(8'h95, 8'h00);
		rs(3'h5, 12'hEFF, 7'h49);
		rs(3'h5, 12'hFFF, 7'h48);
		rs(3'h5, 12'h100, 7'h4A);
		rs(3'h6, 12'h000, 7'h4A);
		@(posedge clk) rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		#1 `CK({channel_alarm_flag, temp_over_flag, temp_under_flag, global_alarm_flag}, 8'h00)
		rd(8'h95, 8'h07);
		rd(8'h97, 8'h08);
		rd(8'h81, 8'h0F);
		final_report;
	end
endmodule
`default_nettype wire
